// File: hw/irq_vector_defines.vh
// constants for the interrupt flag and serial irq channel block
`ifndef IRQ_VECTOR_DEFINES_VH
`define IRQ_VECTOR_DEFINES_VH

// bus geometry
`define ADR_W 4
`define DAT_W 32
`define SEL_W 4
`define BYTE_W 8

// register byte offsets
`define OFS_ENABLE 4'h0
`define OFS_FLAGS 4'h4
`define OFS_VECTOR 4'h8
`define OFS_LEVELS 4'hc

// irq_enable_register fields
`define BIT_GLOBAL 31
`define BIT_CMD 7
`define BIT_STYLE_HI 4
`define BIT_STYLE_LO 3
`define BIT_GRANT 2
`define BIT_STSV 1
`define BIT_RESP 0
`define ENABLE_MASK 32'h8000009f
`define ENABLE_RST 32'h00000008

// interrupt_event_flags fields
`define FLAG_MASK 32'h00000087
`define FLAG_RST 32'h00000000

// serial_irq_channel_select fields
`define VEC_W 8
`define CHAN_W 4
`define VEC_MASK 8'h0f
`define VEC_RST 8'h00
`define CHAN_OFF 4'h0

// signalling styles
`define STYLE_HIGH 2'b00
`define STYLE_LOW 2'b01
`define STYLE_RISE 2'b10
`define STYLE_FALL 2'b11

// localities and misc
`define NUM_LOC 5
`define LINE_IDLE_RST 1'b1
`define ZERO32 32'h00000000

`endif

// File: hw/irq_line_shaper.v
// shapes the interrupt request into the selected line signalling style
`timescale 1ns/1ps
`include "irq_vector_defines.vh"

module irq_line_shaper (
    input wire clk_i,
    input wire rst_i,
    input wire req_i,
    input wire [1:0] style_i,
    input wire [`CHAN_W-1:0] channel_i,
    output wire line_o,
    output wire oe_o,
    output wire [`CHAN_W-1:0] channel_o
);

reg line_reg;
reg line_next;
reg oe_reg;
reg [`CHAN_W-1:0] channel_reg;
reg req_prev_reg;

// edge styles give one pulse per rise of the request
wire req_rise = req_i & ~req_prev_reg;

// pick the line level from the style code
always @*
begin
    case (style_i)
        `STYLE_HIGH: line_next = req_i;
        `STYLE_LOW: line_next = ~req_i;
        `STYLE_RISE: line_next = req_rise;
        `STYLE_FALL: line_next = ~req_rise;
        default: line_next = ~req_i;
    endcase
end

// channel zero releases the line entirely
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        line_reg <= `LINE_IDLE_RST;
        oe_reg <= 1'b0;
        channel_reg <= `CHAN_OFF;
        req_prev_reg <= 1'b0;
    end
    else
    begin
        line_reg <= line_next;
        oe_reg <= (channel_i != `CHAN_OFF);
        channel_reg <= channel_i;
        req_prev_reg <= req_i;
    end
end

assign line_o = line_reg;
assign oe_o = oe_reg;
assign channel_o = channel_reg;

endmodule

// File: hw/irq_vector_regs.v
// interrupt event flags, enables and serial irq channel behind wishbone
//
// What this block does
// - command-ready rising edge sets flag bit 7.
// - flags clear only on a written one; written zeros do nothing.
// - delayed locality grant sets flag bit 2.
// - an immediate grant with no owner active sets no flag.
// - status-valid rising edge sets flag bit 1.
// - response-ready rising edge sets flag bit 0.
// - response event counts only while status-valid is also high.
// - flag bits 31:8 and 6:3 read as zero.
// - channel field 3:0 resets to zero; zero disables and floats the line.
// - channel register bits 7:4 read zero and ignore writes.
// - interrupt held inactive while global enable is zero or changing.
// - with global enable bit 31 set, each flag gated by its enable.
// - low level style, code 01, is the default; others also offered.
// - only ordinary irq slots, channels 1 to 15, never pci slots.
//
// Decided for this implementation: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "irq_vector_defines.vh"

module irq_vector_regs (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [`ADR_W-1:0] adr_i,
    input wire [`SEL_W-1:0] sel_i,
    input wire [`DAT_W-1:0] dat_i,
    output wire [`DAT_W-1:0] dat_o,
    output wire ack_o,
    input wire cmd_ready_indication_i,
    input wire status_valid_indication_i,
    input wire response_ready_indication_i,
    input wire [`NUM_LOC-1:0] use_request_bit_i,
    input wire [`NUM_LOC-1:0] granted_owner_bit_i,
    output wire irq_o,
    output wire serial_irq_level_o,
    output wire serial_irq_oe_o,
    output wire [`CHAN_W-1:0] serial_irq_channel_o
);

// true on a 0 to 1 step between two samples
// one shared gate, so every detector in the block behaves alike
function rose;
    input now_v;
    input was_v;
    begin
        rose = now_v & ~was_v;
    end
endfunction

// expands byte selects to a bit mask
// unselected lanes give zero bits, so they neither set nor clear
function [`DAT_W-1:0] lane_mask;
    input [`SEL_W-1:0] sel_v;
    integer j;
    begin
        lane_mask = `ZERO32;
        for (j = 0; j < `SEL_W; j = j + 1)
            lane_mask[j*`BYTE_W +: `BYTE_W] = {`BYTE_W{sel_v[j]}};
    end
endfunction

// bus side registers
// read data is registered, so dat_o never follows the address
// decode and reads zero outside an answer
reg ack_reg;
reg [`DAT_W-1:0] dat_reg;
reg [`DAT_W-1:0] dat_next;

// software visible state
// reserved bits are masked on every write, so no path can load
// a one into them and reads need no second mask
reg [`DAT_W-1:0] enable_reg;
reg [`DAT_W-1:0] enable_next;
reg [`DAT_W-1:0] flags_reg;
reg [`DAT_W-1:0] flags_next;
reg [`VEC_W-1:0] vector_reg;
reg [`VEC_W-1:0] vector_next;

// event tracking
// each indication is compared with its value one edge earlier;
// the indications come from logic on this clock, so no synchroniser
// stands in front of them
reg cmd_prev_reg;
reg stsv_prev_reg;
reg resp_prev_reg;
reg [`NUM_LOC-1:0] granted_prev_reg;
reg [`NUM_LOC-1:0] delayed_reg;
reg [`NUM_LOC-1:0] delayed_next;
reg grant_event;
reg [`DAT_W-1:0] set_bits;

// interrupt gating
reg hold_reg;
reg irq_reg;
reg irq_next;
reg glob_chg;
reg [`DAT_W-1:0] pending;
// loop index over the localities
integer k;

// a fresh request is taken in the cycle before ack
// a strobe held past its answer is taken again once ack drops, so
// the master must release it as soon as it sees ack
wire take = cyc_i & stb_i & ~ack_reg;
wire wr = take & we_i;
wire rd = take & ~we_i;
// one compare per register; any other offset reads zero
wire hit_enable = (adr_i == `OFS_ENABLE);
wire hit_flags = (adr_i == `OFS_FLAGS);
wire hit_vector = (adr_i == `OFS_VECTOR);
wire hit_levels = (adr_i == `OFS_LEVELS);
// byte lanes as bits, shared by the enable and flag writes below
wire [`DAT_W-1:0] wmask = lane_mask(sel_i);

// response event only counts with status valid also high
// a response seen while status is not yet valid would be a false
// completion, so both must be high before the edge counts
wire resp_now = response_ready_indication_i &
                status_valid_indication_i;

// locality grant bookkeeping
// a request is marked delayed only when another owner holds the grant,
// so a request written with nobody active never raises the flag
// the grant bit is compared with its own previous sample, so an
// owner that keeps its grant raises nothing further
always @*
begin
    delayed_next = delayed_reg;
    grant_event = 1'b0;
    for (k = 0; k < `NUM_LOC; k = k + 1)
    begin
        if (rose(granted_owner_bit_i[k], granted_prev_reg[k]) &&
            delayed_reg[k])
            grant_event = 1'b1;
        if (granted_owner_bit_i[k] || !use_request_bit_i[k])
            delayed_next[k] = 1'b0;
        else if ((granted_owner_bit_i &
                  ~(`NUM_LOC'd1 << k)) != {`NUM_LOC{1'b0}})
            delayed_next[k] = 1'b1;
    end
end

// collect the events of this cycle
// all sources fold into one word, so the flag update below is a
// single mask operation
always @*
begin
    set_bits = `ZERO32;
    set_bits[`BIT_CMD] = rose(cmd_ready_indication_i,
                              cmd_prev_reg);
    set_bits[`BIT_GRANT] = grant_event;
    set_bits[`BIT_STSV] = rose(status_valid_indication_i,
                               stsv_prev_reg);
    set_bits[`BIT_RESP] = rose(resp_now, resp_prev_reg);
end

// flags: write one clears, a set in the same cycle wins
// so software never loses an event that it has not yet seen;
// a read clears nothing, only a written one acknowledges
always @*
begin
    flags_next = flags_reg;
    if (wr && hit_flags)
        flags_next = flags_next & ~(dat_i & wmask);
    flags_next = (flags_next | set_bits) & `FLAG_MASK;
end

// enable register, reserved bits stay zero
// byte lanes are honoured, so a partial write leaves the other
// enables and the style field alone
always @*
begin
    enable_next = enable_reg;
    if (wr && hit_enable)
        enable_next = ((enable_reg & ~wmask) | (dat_i & wmask)) &
                      `ENABLE_MASK;
end

// a write that flips the global enable blanks the request
// only lane 3 carries the global bit; a write without it cannot
// change the enable and needs no blanking
always @*
begin
    glob_chg = 1'b0;
    if (wr && hit_enable && sel_i[3] &&
        (dat_i[`BIT_GLOBAL] != enable_reg[`BIT_GLOBAL]))
        glob_chg = 1'b1;
end

// channel select, upper nibble is read only zero
// the channel lives in lane 0; the upper nibble is dropped by the
// mask rather than stored
always @*
begin
    vector_next = vector_reg;
    if (wr && hit_vector && sel_i[0])
        vector_next = dat_i[`VEC_W-1:0] & `VEC_MASK;
end

// read data mux, unmapped offsets read zero
// the levels word is a raw view of the indications for debug;
// it carries no flag and clears nothing
always @*
begin
    dat_next = `ZERO32;
    if (rd)
    begin
        if (hit_enable)
            dat_next = enable_reg;
        else if (hit_flags)
            dat_next = flags_reg;
        else if (hit_vector)
            dat_next = {{(`DAT_W-`VEC_W){1'b0}}, vector_reg};
        else if (hit_levels)
        begin
            dat_next[`BIT_CMD] = cmd_ready_indication_i;
            dat_next[`BIT_STSV] = status_valid_indication_i;
            dat_next[`BIT_RESP] = response_ready_indication_i;
        end
    end
end

// request level: only enabled flags count, only under global enable
// registered one cycle behind the flags, which keeps irq_o free of
// glitches from the bus decode
always @*
begin
    pending = flags_reg & enable_reg & `FLAG_MASK;
    irq_next = 1'b0;
    if (enable_reg[`BIT_GLOBAL] && !hold_reg && !glob_chg)
        irq_next = (pending != `ZERO32);
end

// bus handshake: ack one cycle after the request, dropped next cycle
// a fixed single wait state keeps every register answer alike
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        ack_reg <= 1'b0;
        dat_reg <= `ZERO32;
    end
    else
    begin
        ack_reg <= take;
        dat_reg <= dat_next;
    end
end

// software visible state
// enable resets to the low level style with every source off
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        enable_reg <= `ENABLE_RST;
        flags_reg <= `FLAG_RST;
        vector_reg <= `VEC_RST;
    end
    else
    begin
        enable_reg <= enable_next;
        flags_reg <= flags_next;
        vector_reg <= vector_next;
    end
end

// previous samples for edge detection
// they reset low, so an indication already high as reset ends is
// taken as a rise and sets its flag on the first edge
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        cmd_prev_reg <= 1'b0;
        stsv_prev_reg <= 1'b0;
        resp_prev_reg <= 1'b0;
        granted_prev_reg <= {`NUM_LOC{1'b0}};
    end
    else
    begin
        cmd_prev_reg <= cmd_ready_indication_i;
        stsv_prev_reg <= status_valid_indication_i;
        resp_prev_reg <= resp_now;
        granted_prev_reg <= granted_owner_bit_i;
    end
end

// delayed requests per locality, forgotten once granted or withdrawn
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        delayed_reg <= {`NUM_LOC{1'b0}};
    end
    else
    begin
        delayed_reg <= delayed_next;
    end
end

// interrupt level and the blanking cycle after a global change
// holding one extra cycle covers the edge where enable itself moves
// glob_chg itself blanks the cycle of the write
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        hold_reg <= 1'b0;
        irq_reg <= 1'b0;
    end
    else
    begin
        hold_reg <= glob_chg;
        irq_reg <= irq_next;
    end
end

// line shaping and channel; only a 4-bit channel can be chosen, so the
// pci slots of the serial stream are out of reach by construction
// style and channel reach the pins one cycle after they are written
irq_line_shaper u_shaper (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(irq_reg),
    .style_i(enable_reg[`BIT_STYLE_HI:`BIT_STYLE_LO]),
    .channel_i(vector_reg[`CHAN_W-1:0]),
    .line_o(serial_irq_level_o),
    .oe_o(serial_irq_oe_o),
    .channel_o(serial_irq_channel_o)
);

// every output comes straight from a register
assign dat_o = dat_reg;
assign ack_o = ack_reg;
assign irq_o = irq_reg;

endmodule

// File: sim/irq_vector_chk.sv
// port checker for the irq flag and serial irq vector block
`timescale 1ns/1ps
`include "irq_vector_defines.vh"
module irq_vector_chk (
    input wire clk_i,
    input wire rst_i,
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [`ADR_W-1:0] adr_i,
    input wire [`SEL_W-1:0] sel_i,
    input wire [`DAT_W-1:0] dat_i,
    input wire [`DAT_W-1:0] dat_o,
    input wire ack_o,
    input wire irq_o,
    input wire serial_irq_level_o,
    input wire serial_irq_oe_o,
    input wire [`CHAN_W-1:0] serial_irq_channel_o
);
    reg glob_reg;
    reg [1:0] style_reg;
    reg [`ADR_W-1:0] adr_reg;
    reg [`CHAN_W-1:0] chan_reg;
    wire take = cyc_i && stb_i && !ack_o;
    wire en_wr = take && we_i && adr_i == `OFS_ENABLE;
    // shadow of what software wrote; the bus is the only way in
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            glob_reg <= 1'b0;
            style_reg <= `STYLE_LOW;
            adr_reg <= 4'h0;
            chan_reg <= `CHAN_OFF;
        end
        else
        begin
            if (en_wr && sel_i[3])
                glob_reg <= dat_i[`BIT_GLOBAL];
            if (en_wr && sel_i[0])
                style_reg <= dat_i[4:3];
            if (take)
                adr_reg <= adr_i;
            if (take && we_i && adr_i == `OFS_VECTOR && sel_i[0])
                chan_reg <= dat_i[3:0];
        end
    end
    default clocking dc @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    ack_next_a: assert property (take |=> ack_o)
        else $error("no answer");
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack too long");
    flag_rsv_a: assert property (
        ack_o && adr_reg == `OFS_FLAGS |-> (dat_o & ~`FLAG_MASK) == 0)
        else $error("flag reserved bits set");
    vec_rsv_a: assert property (
        ack_o && adr_reg == `OFS_VECTOR |-> dat_o[31:4] == 28'h0)
        else $error("vector upper bits set");
    oe_chan_a: assert property (
        serial_irq_oe_o == (serial_irq_channel_o != `CHAN_OFF))
        else $error("driver and channel disagree");
    chan_follow_a: assert property (
        serial_irq_channel_o == $past(chan_reg))
        else $error("channel not as written");
    glob_off_a: assert property (!glob_reg |-> !irq_o)
        else $error("irq while disabled");
    glob_flip_a: assert property (
        en_wr && sel_i[3] && dat_i[31] != glob_reg |=> !irq_o [*2])
        else $error("irq during enable change");
    line_lvl_a: assert property (
        !$past(style_reg[1]) |->
        serial_irq_level_o == ($past(irq_o) ^ $past(style_reg[0])))
        else $error("level style wrong");
    cover property (irq_o);
    cover property (serial_irq_oe_o);
    cover property (style_reg == `STYLE_RISE && serial_irq_level_o);
    cover property (en_wr && !dat_i[31] && glob_reg);
endmodule
bind irq_vector_regs irq_vector_chk chk (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .irq_o,
    .serial_irq_level_o, .serial_irq_oe_o, .serial_irq_channel_o);

// File: sim/sirq_host_model.sv
// host end of the serial irq wire
`timescale 1ns/1ps
module sirq_host_model (
    input wire line_i,
    input wire oe_i,
    output wire wire_o
);
    // pull-up holds the wire high while the device floats
    assign wire_o = oe_i ? line_i : 1'b1;
endmodule

// File: sim/irq_vector_regs_tb.sv
// self-checking bench for the irq flag and vector block
`timescale 1ns/1ps
`include "irq_vector_defines.vh"
module irq_vector_regs_tb;
    reg clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    reg we_i = 1'b0, cmd = 1'b0, sv = 1'b0, rr = 1'b0;
    reg [3:0] adr_i = 4'h0, sel_i = 4'hf;
    reg [31:0] dat_i = 32'h0, q;
    reg [4:0] req = 5'h0, own = 5'h0;
    wire [31:0] dat_o;
    wire [3:0] chan;
    wire ack_o, irq_o, line, oe, pin;
    integer num_errors = 0, n_checks = 0, s;
    irq_vector_regs uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i, .dat_i, .dat_o, .ack_o, .cmd_ready_indication_i(cmd),
        .status_valid_indication_i(sv), .response_ready_indication_i(rr),
        .use_request_bit_i(req), .granted_owner_bit_i(own), .irq_o,
        .serial_irq_level_o(line), .serial_irq_oe_o(oe),
        .serial_irq_channel_o(chan));
    sirq_host_model host (.line_i(line), .oe_i(oe), .wire_o(pin));
    // free-running clock
    initial forever #2.5 clk_i = ~clk_i;
    task report_and_stop;
        begin
            $display("checks %0d errors %0d", n_checks, num_errors);
            if (num_errors == 0 && n_checks > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp)
            begin
                $display("ERROR %0t got %h want %h", $time, got, exp);
                num_errors = num_errors + 1;
            end
        end
    endtask
    // one classic cycle; ack is seen as it stood before the edge
    task bus(input [3:0] a, input w, input [31:0] d);
        integer i;
        begin
            adr_i <= a;
            we_i <= w;
            dat_i <= d;
            cyc_i <= 1'b1;
            stb_i <= 1'b1;
            i = 0;
            @(posedge clk_i);
            while (ack_o !== 1'b1 && i < 20)
            begin
                @(posedge clk_i);
                i = i + 1;
            end
            q = dat_o;
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
            @(posedge clk_i);
            if (i == 20)
            begin
                $display("ERROR %0t bus timeout", $time);
                num_errors = num_errors + 1;
                report_and_stop;
            end
        end
    endtask
    task rd(input [3:0] a, input [31:0] e);
        begin
            bus(a, 1'b0, 32'h0);
            chk(q, e);
        end
    endtask
    task t_reset;
        begin
            rd(`OFS_ENABLE, `ENABLE_RST);
            rd(`OFS_VECTOR, 32'h0);
            rd(`OFS_FLAGS, 32'h0);
            chk({29'h0, irq_o, oe, pin}, 32'h1);
            $display("reset test done");
        end
    endtask
    task t_events;
        begin
            bus(`OFS_ENABLE, 1'b1, 32'h8000008f);
            cmd <= 1'b1;
            sv <= 1'b1;
            @(posedge clk_i);
            rd(`OFS_FLAGS, 32'h82);
            chk({31'h0, irq_o}, 32'h1);
            bus(`OFS_FLAGS, 1'b1, 32'h0);
            rd(`OFS_FLAGS, 32'h82);
            sv <= 1'b0;
            rr <= 1'b1;
            bus(`OFS_FLAGS, 1'b1, 32'hffffff7f);
            rd(`OFS_FLAGS, 32'h80);
            bus(`OFS_ENABLE, 1'b1, 32'h80000008);
            chk({31'h0, irq_o}, 32'h0);
            sv <= 1'b1;
            @(posedge clk_i);
            rd(`OFS_FLAGS, 32'h83);
            bus(`OFS_ENABLE, 1'b1, 32'h0000008f);
            chk({31'h0, irq_o}, 32'h0);
            bus(`OFS_ENABLE, 1'b1, 32'h8000008f);
            @(posedge clk_i);
            chk({31'h0, irq_o}, 32'h1);
            bus(`OFS_FLAGS, 1'b1, 32'hff);
            chk({31'h0, irq_o}, 32'h0);
            rd(`OFS_LEVELS, 32'h83);
            $display("event test done");
        end
    endtask
    task t_grant;
        begin
            req <= 5'h02;
            @(posedge clk_i);
            own <= 5'h02;
            @(posedge clk_i);
            rd(`OFS_FLAGS, 32'h0);
            req <= 5'h04;
            @(posedge clk_i);
            own <= 5'h04;
            @(posedge clk_i);
            rd(`OFS_FLAGS, 32'h4);
            bus(`OFS_FLAGS, 1'b1, 32'h4);
            $display("grant test done");
        end
    endtask
    task t_vector;
        begin
            bus(`OFS_VECTOR, 1'b1, 32'hf5);
            rd(`OFS_VECTOR, 32'h05);
            chk({27'h0, oe, chan}, 32'h15);
            sel_i <= 4'he;
            bus(`OFS_VECTOR, 1'b1, 32'h0);
            sel_i <= 4'hf;
            rd(`OFS_VECTOR, 32'h05);
            rd(4'h1, 32'h0);
            // all four styles through the pulled-up wire, then pulse end
            for (s = 0; s < 4; s = s + 1)
            begin
                bus(`OFS_ENABLE, 1'b1, 32'h80000080 | (s << 3));
                cmd <= 1'b0;
                @(posedge clk_i);
                cmd <= 1'b1;
                repeat (4) @(posedge clk_i);
                chk({31'h0, pin}, {31'h0, !s[0]});
                @(posedge clk_i);
                chk({31'h0, pin}, {31'h0, s[1] ^ !s[0]});
                bus(`OFS_FLAGS, 1'b1, 32'h80);
            end
            bus(`OFS_VECTOR, 1'b1, 32'h0);
            chk({30'h0, oe, pin}, 32'h1);
            $display("vector test done");
        end
    endtask
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset;
        t_events;
        t_grant;
        t_vector;
        report_and_stop;
    end
endmodule
